//--- hw/fsw_pkg.sv
// Package of constants and types for the parallel flash host controller
// Behaviour
// - Host presents valid address for status reads
// - Host waits recovery time after a hardware reset; after system reset it accepts commands at once
// - Host restarts program or erase cut by a hardware reset; system reset clears the replay
// - Unlock writes precede every program and erase
package fsw_pkg;
	// Clock and pin timing, in ns and in cycles of clk_sys
	localparam int CLK_NS       = 10;
	localparam int WE_LOW_NS    = 40;   // Well above the 5 ns glitch filter
	localparam int WE_HIGH_NS   = 30;
	localparam int RC_NS        = 70;   // read_cycle_time
	localparam int RP_NS        = 500;  // reset_pulse_time
	localparam int RHR_NS       = 50;   // reset_recovery_time
	localparam int SETTLE_NS    = 100;  // Ready/busy settle after last strobe
	localparam int WE_LOW_CYC   = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_HIGH_CYC  = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RC_CYC       = (RC_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC       = (RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RHR_CYC      = (RHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_CYC     = 2;    // Depth of the pin synchronisers
	localparam int CNT_W        = 8;

	// Flash geometry
	localparam int FA_W = 22;
	localparam int FD_W = 16;

	// Boot area word ranges, by variant
	localparam logic [21:0] BOOT_BU_LO = 22'h000000;
	localparam logic [21:0] BOOT_BU_HI = 22'h007FFF;
	localparam logic [21:0] BOOT_TU_LO = 22'h3F8000;
	localparam logic [21:0] BOOT_TU_HI = 22'h3FFFFF;
	localparam logic [21:0] BOOT_BN_LO = 22'h000000;
	localparam logic [21:0] BOOT_BN_HI = 22'h001FFF;
	localparam logic [21:0] BOOT_TN_LO = 22'h3FE000;
	localparam logic [21:0] BOOT_TN_HI = 22'h3FFFFF;

	// Register byte offsets on the AHB-Lite side
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA  = 8'h10;
	localparam logic [7:0] REG_CFG    = 8'h14;

	// Field positions
	localparam int CTRL_RST_BIT = 31;
	localparam int ST_BUSY      = 0;
	localparam int ST_DONE      = 1;
	localparam int ST_REFUSED   = 2;
	localparam int ST_RESTART   = 3;
	localparam int ST_RB        = 4;
	localparam int CFG_WP       = 0;
	localparam logic [31:0] CFG_RESET = 32'h0000_0001;

	// Operations software may start
	typedef enum logic [3:0] {
		OP_READ       = 4'h0,
		OP_PROGRAM    = 4'h1,
		OP_BLK_ERASE  = 4'h2,
		OP_CHIP_ERASE = 4'h3,
		OP_QRY_ENTRY  = 4'h4,
		OP_QRY_EXIT   = 4'h5,
		OP_ID_ENTRY   = 4'h6,
		OP_ID_EXIT    = 4'h7,
		OP_ABORT_RST  = 4'h8,
		OP_HW_RESET   = 4'h9,
		OP_RAW_WRITE  = 4'hA
	} fsw_op_e;

	// Boot variants
	typedef enum logic [1:0] {
		BV_BOT_UNI = 2'b00,
		BV_TOP_UNI = 2'b01,
		BV_BOT_NON = 2'b10,
		BV_TOP_NON = 2'b11
	} fsw_boot_e;

	// One write cycle of a command sequence
	typedef struct packed {
		logic [FA_W-1:0] addr;
		logic [FD_W-1:0] data;
		logic            last;
	} fsw_wr_s;

	// Flash strobes and address driven by the host
	typedef struct packed {
		logic [FA_W-1:0] addr;
		logic            ce_n;
		logic            oe_n;
		logic            we_n;
		logic            wp_n;
		logic            rst_n;
	} fsw_pins_s;
endpackage : fsw_pkg

//--- hw/fsw_host.sv
// Host controller that sequences commands onto a parallel NOR flash
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module fsw_host
	import fsw_pkg::*;
#(
	parameter logic [21:0] UNLOCK_ADDR1 = 22'h000555,
	parameter logic [21:0] UNLOCK_ADDR2 = 22'h0002AA,
	parameter logic [21:0] QUERY_ADDR   = 22'h000055,
	parameter logic [15:0] UNLOCK_DATA1 = 16'h00AA,
	parameter logic [15:0] UNLOCK_DATA2 = 16'h0055,
	parameter logic [15:0] CMD_PROGRAM  = 16'h00A0,
	parameter logic [15:0] CMD_ERASE    = 16'h0080,
	parameter logic [15:0] CMD_BLOCK    = 16'h0030,
	parameter logic [15:0] CMD_CHIP     = 16'h0010,
	parameter logic [15:0] CMD_QUERY    = 16'h0098,
	parameter logic [15:0] CMD_ID       = 16'h0090,
	parameter logic [15:0] CMD_EXIT     = 16'h00F0
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Flash pins
	output fsw_pins_s        flash_pins,
	output logic [15:0]      dq_out,
	output logic             dq_oe_n,
	input  wire logic [15:0] dq_in,
	input  wire logic        ready_busy_n
);
	if (WE_LOW_CYC < 1 || RP_CYC >= (1 << CNT_W)
			|| RC_CYC + SYNC_CYC >= (1 << CNT_W)) begin : g_bad_cnt
		$error("fsw_host: timing counts do not fit the counter");
	end

	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_WSETUP = 4'h1,
		S_WLOW   = 4'h2,
		S_WHIGH  = 4'h3,
		S_SETTLE = 4'h4,
		S_WAITRB = 4'h5,
		S_READ   = 4'h6,
		S_RSTLO  = 4'h7,
		S_RSTREC = 4'h8
	} fsw_state_e;

	fsw_state_e        state_reg;
	fsw_op_e           op_reg;
	logic [CNT_W-1:0]  cnt_reg;
	logic [2:0]        step_reg;
	logic [21:0]       addr_reg;
	logic [15:0]       wdata_reg;
	logic [15:0]       rdata_reg;
	logic [31:0]       cfg_reg;
	logic              done_reg;
	logic              refused_reg;
	logic              restart_reg;
	logic [1:0]        rb_sync_reg;
	logic [15:0]       dq_s1_reg;
	logic [15:0]       dq_s2_reg;
	logic              a_wr_reg;
	logic              a_vld_reg;
	logic [7:0]        a_off_reg;
	fsw_wr_s           cur_wr;
	logic              is_alter;
	logic              boot_hit;
	logic              wr_ctrl;
	logic              wr_status;
	logic              hw_rst_req;

	// Write list of each command sequence; unlock pairs come first for program, erase, id entry and abort reset
	function automatic fsw_wr_s seq_step(input fsw_op_e op, input logic [2:0] st,
			input logic [21:0] a, input logic [15:0] d);
		fsw_wr_s w;
		w = '{addr: UNLOCK_ADDR1, data: UNLOCK_DATA1, last: 1'b0};
		if (st == 3'd1 || st == 3'd4) begin
			w.addr = UNLOCK_ADDR2;
			w.data = UNLOCK_DATA2;
		end
		case (op)
			OP_PROGRAM: begin
				if (st == 3'd2) w.data = CMD_PROGRAM;
				if (st == 3'd3) w = '{addr: a, data: d, last: 1'b1};
			end
			OP_BLK_ERASE, OP_CHIP_ERASE: begin
				if (st == 3'd2) w.data = CMD_ERASE;
				if (st == 3'd5) begin
					w.addr = (op == OP_BLK_ERASE) ? a : UNLOCK_ADDR1;
					w.data = (op == OP_BLK_ERASE) ? CMD_BLOCK : CMD_CHIP;
					w.last = 1'b1;
				end
			end
			OP_QRY_ENTRY: w = '{addr: QUERY_ADDR, data: CMD_QUERY, last: 1'b1};
			OP_ID_ENTRY, OP_ABORT_RST: begin
				if (st == 3'd2) begin
					w.data = (op == OP_ID_ENTRY) ? CMD_ID : CMD_EXIT;
					w.last = 1'b1;
				end
			end
			OP_QRY_EXIT, OP_ID_EXIT: w = '{addr: a, data: CMD_EXIT, last: 1'b1};
			default: w = '{addr: a, data: d, last: 1'b1};
		endcase
		return w;
	endfunction : seq_step

	// Boot range check for the selected variant
	always_comb begin
		case (fsw_boot_e'(cfg_reg[2:1]))
			BV_BOT_UNI: boot_hit = addr_reg >= BOOT_BU_LO && addr_reg <= BOOT_BU_HI;
			BV_TOP_UNI: boot_hit = addr_reg >= BOOT_TU_LO && addr_reg <= BOOT_TU_HI;
			BV_BOT_NON: boot_hit = addr_reg >= BOOT_BN_LO && addr_reg <= BOOT_BN_HI;
			BV_TOP_NON: boot_hit = addr_reg >= BOOT_TN_LO && addr_reg <= BOOT_TN_HI;
			default:    boot_hit = 1'b0;
		endcase
	end

	assign cur_wr   = seq_step(op_reg, step_reg, addr_reg, wdata_reg);
	assign is_alter = op_reg == OP_PROGRAM || op_reg == OP_BLK_ERASE || op_reg == OP_CHIP_ERASE;

	// AHB-Lite address phase capture; zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			a_vld_reg <= 1'b0;
			a_wr_reg  <= 1'b0;
			a_off_reg <= 8'h00;
		end else if (hready) begin
			a_vld_reg <= hsel && htrans[1];
			a_wr_reg  <= hwrite;
			a_off_reg <= {haddr[7:2], 2'b00};
		end
	end

	assign wr_ctrl    = a_vld_reg && a_wr_reg && a_off_reg == REG_CTRL;
	assign wr_status  = a_vld_reg && a_wr_reg && a_off_reg == REG_STATUS;
	assign hw_rst_req = wr_ctrl && hwdata[CTRL_RST_BIT];

	// Read mux; unmapped offsets read as zero
	always_comb begin
		hrdata = 32'h0000_0000;
		case (a_off_reg)
			REG_CTRL:   hrdata = {28'h0000000, op_reg};
			REG_ADDR:   hrdata = {10'h000, addr_reg};
			REG_WDATA:  hrdata = {16'h0000, wdata_reg};
			REG_STATUS: hrdata = {27'h0000000, rb_sync_reg[1], restart_reg, refused_reg,
					done_reg, state_reg != S_IDLE};
			REG_RDATA:  hrdata = {16'h0000, rdata_reg};
			REG_CFG:    hrdata = cfg_reg;
			default:    hrdata = 32'h0000_0000;
		endcase
	end

	// Software registers; address and data frozen while a sequence runs
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addr_reg  <= 22'h000000;
			wdata_reg <= 16'h0000;
			cfg_reg   <= CFG_RESET;
		end else if (a_vld_reg && a_wr_reg && state_reg == S_IDLE) begin
			if (a_off_reg == REG_ADDR)  addr_reg  <= hwdata[21:0];
			if (a_off_reg == REG_WDATA) wdata_reg <= hwdata[15:0];
			if (a_off_reg == REG_CFG)   cfg_reg   <= {29'h00000000, hwdata[2:0]};
		end
	end

	// Two-stage synchronisers for pins that change outside clk_sys
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rb_sync_reg <= 2'b11;
			dq_s1_reg   <= 16'h0000;
			dq_s2_reg   <= 16'h0000;
		end else begin
			rb_sync_reg <= {rb_sync_reg[0], ready_busy_n};
			dq_s1_reg   <= dq_in;
			dq_s2_reg   <= dq_s1_reg;
		end
	end

	// Sequencer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			op_reg    <= OP_READ;
			step_reg  <= 3'd0;
			cnt_reg   <= '0;
		end else if (hw_rst_req && state_reg != S_RSTLO && state_reg != S_RSTREC) begin
			state_reg <= S_RSTLO;
			cnt_reg   <= CNT_W'(RP_CYC);
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (wr_ctrl && !hwdata[CTRL_RST_BIT]) begin
						op_reg   <= fsw_op_e'(hwdata[3:0]);
						step_reg <= 3'd0;
						if (fsw_op_e'(hwdata[3:0]) == OP_READ) begin
							state_reg <= S_READ;
							cnt_reg   <= CNT_W'(RC_CYC + SYNC_CYC);
						end else if (fsw_op_e'(hwdata[3:0]) == OP_HW_RESET) begin
							state_reg <= S_RSTLO;
							cnt_reg   <= CNT_W'(RP_CYC);
						end else if (!refuse_now(fsw_op_e'(hwdata[3:0]))) begin
							state_reg <= S_WSETUP;
						end
					end else if (restart_reg) begin
						state_reg <= S_WSETUP;
						step_reg  <= 3'd0;
					end
				end
				S_WSETUP: begin
					state_reg <= S_WLOW;
					cnt_reg   <= CNT_W'(WE_LOW_CYC);
				end
				S_WLOW: begin
					cnt_reg <= cnt_reg - 1'b1;
					if (cnt_reg == CNT_W'(1)) begin
						state_reg <= S_WHIGH;
						cnt_reg   <= CNT_W'(WE_HIGH_CYC);
					end
				end
				S_WHIGH: begin
					cnt_reg <= cnt_reg - 1'b1;
					if (cnt_reg == CNT_W'(1)) begin
						if (!cur_wr.last) begin
							state_reg <= S_WSETUP;
							step_reg  <= step_reg + 3'd1;
						end else if (is_alter) begin
							state_reg <= S_SETTLE;
							cnt_reg   <= CNT_W'(SETTLE_CYC + SYNC_CYC);
						end else begin
							state_reg <= S_IDLE;
						end
					end
				end
				S_SETTLE: begin
					cnt_reg <= cnt_reg - 1'b1;
					if (cnt_reg == CNT_W'(1)) state_reg <= S_WAITRB;
				end
				S_WAITRB: begin
					if (rb_sync_reg[1]) begin
						state_reg <= S_READ;
						cnt_reg   <= CNT_W'(RC_CYC + SYNC_CYC);
					end
				end
				S_READ: begin
					cnt_reg <= cnt_reg - 1'b1;
					if (cnt_reg == CNT_W'(1)) state_reg <= S_IDLE;
				end
				S_RSTLO: begin
					cnt_reg <= cnt_reg - 1'b1;
					if (cnt_reg == CNT_W'(1)) begin
						state_reg <= S_RSTREC;
						cnt_reg   <= CNT_W'(RHR_CYC);
					end
				end
				S_RSTREC: begin
					cnt_reg <= cnt_reg - 1'b1;
					if (cnt_reg == CNT_W'(1)) state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Boot area writes are refused here when protection is on, so the flash never aborts
	function automatic logic refuse_now(input fsw_op_e op);
		logic alter;
		alter = op == OP_PROGRAM || op == OP_BLK_ERASE || op == OP_CHIP_ERASE;
		return alter && !cfg_reg[CFG_WP] && (boot_hit || op == OP_CHIP_ERASE);
	endfunction : refuse_now

	// Sticky flags; a new event wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			done_reg    <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			if (state_reg != S_IDLE && fsw_state_e'(state_reg) != S_RSTLO
					&& ((state_reg == S_READ || state_reg == S_RSTREC || state_reg == S_WHIGH)
					&& cnt_reg == CNT_W'(1) && (state_reg != S_WHIGH
					|| (cur_wr.last && !is_alter))))
				done_reg <= 1'b1;
			else if (wr_status && hwdata[ST_DONE])
				done_reg <= 1'b0;
			if (state_reg == S_IDLE && wr_ctrl && !hwdata[CTRL_RST_BIT]
					&& refuse_now(fsw_op_e'(hwdata[3:0])))
				refused_reg <= 1'b1;
			else if (wr_status && hwdata[ST_REFUSED])
				refused_reg <= 1'b0;
		end
	end

	// An alter cut by a hardware reset is replayed once recovery ends
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			restart_reg <= 1'b0;
		else if (hw_rst_req && is_alter && state_reg != S_IDLE && state_reg != S_READ
				&& state_reg != S_RSTLO && state_reg != S_RSTREC)
			restart_reg <= 1'b1;
		else if (state_reg == S_IDLE && restart_reg && !wr_ctrl)
			restart_reg <= 1'b0;
	end

	// Captured read word; status reads use the target address
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			rdata_reg <= 16'h0000;
		else if (state_reg == S_READ && cnt_reg == CNT_W'(1))
			rdata_reg <= dq_s2_reg;
	end

	// Pin drivers; write enable only falls while output enable is high
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flash_pins <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, wp_n: 1'b1,
					rst_n: 1'b0};
			dq_out     <= 16'h0000;
			dq_oe_n    <= 1'b1;
		end else begin
			flash_pins.rst_n <= state_reg != S_RSTLO;
			flash_pins.wp_n  <= cfg_reg[CFG_WP];
			flash_pins.ce_n  <= !(state_reg == S_WSETUP || state_reg == S_WLOW
					|| state_reg == S_READ);
			flash_pins.oe_n  <= state_reg != S_READ;
			flash_pins.we_n  <= state_reg != S_WLOW;
			flash_pins.addr  <= (state_reg == S_WSETUP || state_reg == S_WLOW)
					? cur_wr.addr : addr_reg;
			dq_out           <= cur_wr.data;
			dq_oe_n          <= !(state_reg == S_WSETUP || state_reg == S_WLOW
					|| state_reg == S_WHIGH);
		end
	end
endmodule : fsw_host

//--- tb/fsw_host_sva.sv
// Checker on the flash host ports: strobe shapes, reset pulse and read timing
`timescale 1ns/1ps
module fsw_host_sva
	import fsw_pkg::*;
(
	input wire logic      clk_sys,
	input wire logic      rst_n,
	input wire logic      hreadyout,
	input wire logic      hresp,
	input wire fsw_pins_s flash_pins,
	input wire logic      dq_oe_n,
	input wire logic      ready_busy_n
);
	localparam int RP_MIN = RP_CYC;
	logic [CNT_W-1:0] lo_cnt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Flash reset pulse length; counts only from a real falling edge, not from system reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n || flash_pins.rst_n) lo_cnt <= '0;
		else if (lo_cnt != 0 || $fell(flash_pins.rst_n)) lo_cnt <= lo_cnt + 1'b1;
	end
	sequence we_low_s; !flash_pins.we_n [*4]; endsequence
	sequence quiet_s; flash_pins.oe_n [*5]; endsequence
	sequence read_s; (!flash_pins.oe_n && $stable(flash_pins.addr)) [*6]; endsequence
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stalled or errored");
	write_inhibit_a: assert property (!flash_pins.we_n |-> flash_pins.oe_n && !flash_pins.ce_n)
		else $error("write strobe with outputs on or chip off");
	we_width_a: assert property ($fell(flash_pins.we_n) |-> we_low_s)
		else $error("write strobe too short");
	data_drive_a: assert property (!flash_pins.we_n |-> !dq_oe_n)
		else $error("write strobe without data driven");
	no_clash_a: assert property (!flash_pins.oe_n |-> dq_oe_n)
		else $error("host drives data while flash outputs on");
	rst_pulse_a: assert property ($rose(flash_pins.rst_n) && lo_cnt != 0 |-> lo_cnt >= RP_MIN)
		else $error("flash reset pulse too short");
	recovery_a: assert property ($rose(flash_pins.rst_n) |-> quiet_s)
		else $error("read too soon after flash reset");
	busy_read_a: assert property (!ready_busy_n [*4] |-> flash_pins.oe_n)
		else $error("read while flash busy");
	read_hold_a: assert property ($fell(flash_pins.oe_n) |=> read_s)
		else $error("read cycle short or address moved");
endmodule : fsw_host_sva
bind fsw_host fsw_host_sva chk (.clk_sys(clk_sys), .rst_n(rst_n), .hreadyout(hreadyout),
	.hresp(hresp), .flash_pins(flash_pins), .dq_oe_n(dq_oe_n), .ready_busy_n(ready_busy_n));

//--- tb/fsw_flash_model.sv
// Behavioural parallel flash: unlock decoding, busy status, boot protection, id and query
`timescale 1ns/1ps
module fsw_flash_model
	import fsw_pkg::*;
#(
	parameter int          BUSY_NS = 2000,
	parameter logic [15:0] MAKER   = 16'h00C3,
	parameter logic [15:0] PART    = 16'h5A01
) (
	input  wire fsw_pins_s   pins,
	input  wire logic [15:0] dq,
	input  wire fsw_boot_e   boot_v,
	output logic [15:0]      dq_drv,
	output logic             rb_low
);
	logic [15:0] mem [int];
	logic [15:0] pd, ld, last, val;
	logic [21:0] pa, la;
	logic        busy = 0, era = 0, tog = 0, in_id = 0, in_qry = 0, lce, loe;
	int          step = 0, gen = 0;
	realtime     t_fall;
	assign rb_low = busy;
	function automatic logic locked(input logic [21:0] a);
		if (pins.wp_n !== 1'b0) return 1'b0;
		case (boot_v)
			BV_BOT_UNI: return a <= BOOT_BU_HI;
			BV_TOP_UNI: return a >= BOOT_TU_LO;
			BV_BOT_NON: return a <= BOOT_BN_HI;
			default:    return a >= BOOT_TN_LO;
		endcase
	endfunction : locked
	// Program data lands only at completion, so an interrupted program leaves no trace
	task automatic start(input logic e);
		era = e;
		busy = 1;
		gen++;
		fork begin
			automatic int g = gen;
			#(BUSY_NS);
			if (g == gen) begin
				busy = 0;
				if (!e) mem[pa] = pd;
			end
		end join_none
	endtask : start
	task automatic decode(input logic [21:0] a, input logic [15:0] d);
		if (busy) return;
		case (step)
			0: if (a == 22'h555 && d == 16'h00AA) step = 1;
				else if (a == 22'h55 && d == 16'h0098) in_qry = 1;
				else if (d == 16'h00F0) begin in_qry = 0; in_id = 0; end
			1, 4: step = (a == 22'h2AA && d == 16'h0055) ? step + 1 : 0;
			2: begin
				step = (a != 22'h555) ? 0 : (d == 16'h00A0) ? 7 : (d == 16'h0080) ? 3 : 0;
				if (a == 22'h555 && d == 16'h0090) in_id = 1;
			end
			3: step = (a == 22'h555 && d == 16'h00AA) ? 4 : 0;
			7: begin
				step = 0;
				pa = a;
				pd = d;
				if (!locked(a)) start(1'b0);
			end
			default: begin
				step = 0;
				if (d == 16'h0010 && pins.wp_n) begin mem.delete(); start(1'b1); end
				else if (d == 16'h0030 && !locked(a)) begin
					for (int k = 0; k < 32768; k++) mem.delete({a[21:15], 15'h0000} + k);
					start(1'b1);
				end
			end
		endcase
	endtask : decode
	// Strobe state taken just after the fall; ce_n and addr move with the rising edge
	always @(negedge pins.we_n) begin
		t_fall = $realtime;
		#1;
		la = pins.addr;
		ld = dq;
		lce = pins.ce_n;
		loe = pins.oe_n;
	end
	always @(posedge pins.we_n) if (!lce && loe && pins.rst_n && $realtime - t_fall >= 5.0)
		decode(la, ld);
	// Reset pin ends any operation and returns to read mode
	always @(negedge pins.rst_n) begin gen++; busy = 0; step = 0; in_id = 0; in_qry = 0; end
	always @(negedge pins.oe_n) if (busy) tog = ~tog;
	always @(posedge pins.oe_n) last = val;
	// Released bus shows the inverse of the last word so stale data never looks valid
	always @* begin
		if (busy) val = {8'h00, era ? 1'b0 : ~pd[7], tog, 2'b00, era, 3'b000};
		else if (in_id) val = (pins.addr == 22'h0) ? MAKER : PART;
		else if (in_qry) val = 16'h0051;
		else val = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
		dq_drv = (pins.ce_n || pins.oe_n) ? ~last : val;
	end
endmodule : fsw_flash_model

//--- tb/fsw_host_tb_top.sv
// Testbench: register-level operations of the flash host against the flash model
`timescale 1ns/1ps
module fsw_host_tb_top import fsw_pkg::*;;
	localparam logic [15:0] MAKER = 16'h00C3; // Arbitrary maker code
	localparam logic [15:0] PART  = 16'h5A01; // Arbitrary part code
	logic        clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, dq_oe_n, rb_low;
	logic [31:0] haddr, hwdata, hrdata, q, st;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [15:0] dq_out, dq_drv;
	fsw_pins_s   pins;
	fsw_boot_e   bv;
	int          fail_count, num_checks, cyc;
	logic [21:0] inb [4]  = '{22'h007FFF, 22'h3F8000, 22'h001FFF, 22'h3FE000};
	logic [21:0] outb [4] = '{22'h008000, 22'h3F7FFF, 22'h002000, 22'h3FDFFF};
	logic [37:0] bad [4]  = '{{22'h555, 16'h00AA}, {22'h2AA, 16'h0066}, {22'h555, 16'h00A0},
		{22'h040, 16'h0BAD}};
	wire  [15:0] dq_in        = dq_oe_n ? dq_drv : dq_out;
	wire         ready_busy_n = !rb_low;
	fsw_host uut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_pins(pins),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
	fsw_flash_model #(.MAKER(MAKER), .PART(PART)) flash (.pins(pins), .dq(dq_in), .boot_v(bv),
		.dq_drv(dq_drv), .rb_low(rb_low));
	initial begin clk_sys = 0; forever #5 clk_sys = ~clk_sys; end
	// Watchdog well beyond the expected run length
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin fail_count++; summarize(); end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb
	// Poll until idle with no replay pending, keep the status, then clear its sticky flags
	task automatic settle();
		do ahb(1'b0, REG_STATUS, 32'h0); while ((q[ST_BUSY] | q[ST_RESTART]) !== 1'b0);
		st = q & 32'h0000_0006;
		ahb(1'b1, REG_STATUS, 32'h0000_0006);
	endtask : settle
	task automatic op(input logic [3:0] o, input logic [21:0] a, input logic [15:0] d);
		ahb(1'b1, REG_ADDR, {10'h000, a});
		ahb(1'b1, REG_WDATA, {16'h0000, d});
		ahb(1'b1, REG_CTRL, {28'h0000000, o});
		settle();
	endtask : op
	task automatic rd(input logic [21:0] a, input logic [15:0] exp);
		op(OP_READ, a, 16'h0000);
		ahb(1'b0, REG_RDATA, 32'h0);
		chk(q, {16'h0000, exp});
	endtask : rd
	task automatic summarize();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	initial begin
		rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0; hwdata = 0;
		bv = BV_BOT_UNI; fail_count = 0; num_checks = 0; cyc = 0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		ahb(1'b0, REG_STATUS, 32'h0); chk(q, 32'h0000_0010);
		ahb(1'b0, REG_CFG, 32'h0); chk(q, CFG_RESET);
		ahb(1'b0, 8'h20, 32'h0); chk(q, 32'h0);
		op(OP_PROGRAM, 22'h001234, 16'hA55A); chk(st, 32'h2);
		ahb(1'b0, REG_RDATA, 32'h0); chk(q, 32'h0000_A55A);
		// Each boot variant with write protect low: inside refused, just outside accepted
		for (int v = 0; v < 4; v++) begin
			bv <= fsw_boot_e'(v);
			ahb(1'b1, REG_CFG, v << 1);
			op(OP_PROGRAM, inb[v], 16'h1111); chk(st, 32'h4);
			rd(inb[v], 16'hFFFF);
			op(OP_PROGRAM, outb[v], 16'h2222); chk(st, 32'h2);
		end
		bv <= BV_BOT_UNI;
		ahb(1'b1, REG_CFG, 32'h1);
		op(OP_PROGRAM, 22'h007FFF, 16'h3C3C);
		rd(22'h007FFF, 16'h3C3C);
		op(OP_BLK_ERASE, 22'h008000, 16'h0000);
		rd(22'h008000, 16'hFFFF);
		rd(22'h001234, 16'hA55A);
		ahb(1'b1, REG_CFG, 32'h0);
		op(OP_CHIP_ERASE, 22'h0, 16'h0); chk(st, 32'h4);
		ahb(1'b1, REG_CFG, 32'h1);
		op(OP_CHIP_ERASE, 22'h0, 16'h0); chk(st, 32'h2);
		rd(22'h001234, 16'hFFFF);
		foreach (bad[i]) op(OP_RAW_WRITE, bad[i][37:16], bad[i][15:0]);
		rd(22'h000040, 16'hFFFF);
		op(OP_ABORT_RST, 22'h0, 16'h0); chk(st, 32'h2);
		op(OP_ID_ENTRY, 22'h0, 16'h0);
		rd(22'h000000, MAKER);
		rd(22'h000001, PART);
		op(OP_ID_EXIT, 22'h0, 16'h0);
		rd(22'h000000, 16'hFFFF);
		op(OP_QRY_ENTRY, 22'h0, 16'h0);
		rd(22'h000010, 16'h0051);
		op(OP_QRY_EXIT, 22'h0, 16'h0);
		rd(22'h000010, 16'hFFFF);
		// Hardware reset in mid-program; the host must rerun the program
		ahb(1'b1, REG_ADDR, 32'h0000_0100);
		ahb(1'b1, REG_WDATA, 32'h0000_1357);
		ahb(1'b1, REG_CTRL, 32'h0000_0001);
		repeat (60) @(posedge clk_sys);
		ahb(1'b1, REG_CTRL, 32'h8000_0000);
		settle();
		rd(22'h000100, 16'h1357);
		summarize();
	end
endmodule : fsw_host_tb_top
